/* File: drive_level_detection_monitor.sv */
// Ramp sequencing helpers, level and window detectors and timed run of the drive
`timescale 1ns/1ns
// Notes on behaviour
// - Skip bands apply during ramps only when enabled; ramp jumps over the band.
// - Accelerating below accel switch point uses rate set 2, above uses set 1.
// - Decelerating above decel switch point uses rate set 1, below uses set 2.
// - Rate switching only with motor one selected and no terminal ramp selection.
// - Jog priority makes a terminal jog during running enter terminal jog state.
// - Second frequency level detector behaves as the first, with its own flag.
// - Level flag sets above threshold, clears below threshold minus percent hysteresis.
// - Frequency window flag while frequency within centre plus or minus width.
// - Two independent frequency windows with own centre, width and flag.
// - Zero current flag after current at or below level longer than delay.
// - Over-current flag after current above limit longer than delay; zero disables.
// - Two current windows flag current within centre plus or minus width.
// - Timed run counts from start and stops drive and flags on reaching duration.
// - Timed run restarts from zero at each start; remaining time is visible.
// - Timed run counted in tenths of minutes, duration source chosen three ways.
// - Analogue input one flag outside low or high voltage limits.
// - Heatsink flag when temperature reaches the threshold.
module drive_level_detection_monitor #(
	parameter int unsigned DELAY_TICK_LEN = drive_monitor_pkg::DELAY_TICK_CYCLES,
	parameter int unsigned RUN_TICK_LEN = drive_monitor_pkg::RUN_TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire drive_monitor_pkg::measure_t meas,
	input wire logic [15:0] max_freq,
	input wire drive_monitor_pkg::freq_cfg_t freq_cfg,
	input wire drive_monitor_pkg::current_cfg_t current_cfg,
	input wire logic [15:0] ramp_freq,
	input wire logic ramp_accel,
	input wire logic ramp_decel,
	input wire logic ramp_skip_band_enable,
	input wire logic [15:0] skip_band_low,
	input wire logic [15:0] skip_band_high,
	input wire logic [15:0] accel_rate_switch_point,
	input wire logic [15:0] decel_rate_switch_point,
	input wire logic motor_one_selected,
	input wire logic multi_function_input_ramp_select,
	input wire logic jog_priority_enable,
	input wire logic terminal_jog_pin,
	input wire logic running,
	input wire logic run_start,
	input wire logic timed_run_enable,
	input wire logic [1:0] timed_run_source_select,
	input wire logic [15:0] timed_run_duration,
	input wire logic [15:0] timed_run_alt1_duration,
	input wire logic [15:0] timed_run_alt2_duration,
	input wire logic [15:0] analog_in1_low_limit,
	input wire logic [15:0] analog_in1_high_limit,
	input wire logic [7:0] heatsink_temp_threshold,
	output logic [15:0] run_freq_q,
	output logic accel_set2_q,
	output logic decel_set2_q,
	output logic terminal_jog_run_q,
	output logic timed_run_stop_q,
	output logic [15:0] timed_run_remaining_view_q,
	output drive_monitor_pkg::det_flags_t flags
);
	import drive_monitor_pkg::*;

	// Percentage of a base value, percent in 0.01 % steps
	function automatic logic [15:0] pct_of(input logic [15:0] base, input logic [15:0] pct);
		logic [31:0] prod;
		logic [31:0] quot;
		prod = base * pct;
		quot = prod / PCT_FULL_SCALE;
		pct_of = quot[15:0];
	endfunction

	function automatic logic in_window(input logic [15:0] val, input logic [15:0] centre,
		input logic [15:0] width);
		in_window = ({1'b0, val} + {1'b0, width} >= {1'b0, centre})
			&& ({1'b0, val} <= {1'b0, centre} + {1'b0, width});
	endfunction

	// Hysteresis flag: set above threshold, clear only below threshold minus band
	function automatic logic level_next(input logic cur, input logic [15:0] f,
		input logic [15:0] thr, input logic [15:0] hyst);
		logic [15:0] band;
		band = pct_of(thr, hyst);
		if (f > thr)
			level_next = 1'b1;
		else if ({1'b0, f} + {1'b0, band} < {1'b0, thr})
			level_next = 1'b0;
		else
			level_next = cur;
	endfunction

	// Time bases
	logic [31:0] delay_div_q;
	logic [31:0] run_div_q;
	logic delay_tick;
	logic run_tick;
	assign delay_tick = (delay_div_q == DELAY_TICK_LEN - 1);
	assign run_tick = (run_div_q == RUN_TICK_LEN - 1);

	// Skip band during ramps
	logic in_band;
	logic ramping;
	logic [15:0] run_freq_d;
	assign ramping = ramp_accel || ramp_decel;
	assign in_band = (ramp_freq > skip_band_low) && (ramp_freq < skip_band_high);
	// Inside the band the output leaps to the edge ahead of the ramp direction
	assign run_freq_d = !(ramp_skip_band_enable && ramping && in_band) ? ramp_freq
		: ramp_accel ? skip_band_high : skip_band_low;

	// Rate set selection by frequency
	logic rate_switch_active;
	logic accel_set2_d;
	logic decel_set2_d;
	assign rate_switch_active = motor_one_selected && !multi_function_input_ramp_select;
	assign accel_set2_d = rate_switch_active && ramp_accel
		&& (meas.freq < accel_rate_switch_point);
	assign decel_set2_d = rate_switch_active && ramp_decel
		&& (meas.freq < decel_rate_switch_point);

	// Terminal jog arrives from a pin, so it is synchronised first
	logic jog_meta_q;
	logic jog_sync_q;
	logic terminal_jog_run_d;
	assign terminal_jog_run_d = jog_priority_enable && running && jog_sync_q;

	// Level and window detectors
	logic level1_q;
	logic level2_q;
	logic level1_d;
	logic level2_d;
	logic fwin1_q;
	logic fwin2_q;
	logic cwin1_q;
	logic cwin2_q;
	logic ai1_out_q;
	logic heat_q;
	logic fwin1_d;
	logic fwin2_d;
	logic ai1_out_d;
	logic heat_d;
	assign level1_d = level_next(level1_q, meas.freq, freq_cfg.level1_freq_threshold,
		freq_cfg.level1_freq_hysteresis);
	assign level2_d = level_next(level2_q, meas.freq, freq_cfg.level2_freq_threshold,
		freq_cfg.level2_freq_hysteresis);
	// Window width is a share of maximum frequency, not of the centre
	assign fwin1_d = in_window(meas.freq, freq_cfg.freq_window1_centre,
		pct_of(max_freq, freq_cfg.freq_window1_width));
	assign fwin2_d = in_window(meas.freq, freq_cfg.freq_window2_centre,
		pct_of(max_freq, freq_cfg.freq_window2_width));
	assign ai1_out_d = (meas.ai1_volt > analog_in1_high_limit)
		|| (meas.ai1_volt < analog_in1_low_limit);
	assign heat_d = (meas.heatsink_temp >= heatsink_temp_threshold);

	// Delay-qualified current detectors
	logic zero_cond;
	logic over_cond;
	logic zero_flag;
	logic over_flag;
	assign zero_cond = (meas.current <= current_cfg.zero_current_level);
	// A zero limit means detection is switched off
	assign over_cond = (current_cfg.overcurrent_limit != 16'h0000)
		&& (meas.current > current_cfg.overcurrent_limit);

	delay_qualifier zero_det (
		.clk(clk),
		.rst(rst),
		.cond(zero_cond),
		.tick(delay_tick),
		.delay(current_cfg.zero_current_delay),
		.flag_q(zero_flag)
	);

	delay_qualifier over_det (
		.clk(clk),
		.rst(rst),
		.cond(over_cond),
		.tick(delay_tick),
		.delay(current_cfg.overcurrent_delay),
		.flag_q(over_flag)
	);

	// Timed run
	timed_run_state_t tr_state_q;
	timed_run_state_t tr_state_d;
	logic [15:0] tr_duration;
	logic [15:0] remaining_d;
	logic tr_start;
	logic tr_reached;
	logic tr_flag_q;
	logic tr_flag_d;
	logic tr_stop_d;
	// Unused fourth code falls back to the setting itself
	assign tr_duration = (timed_run_source_select == TR_SRC_ALT1) ? timed_run_alt1_duration
		: (timed_run_source_select == TR_SRC_ALT2) ? timed_run_alt2_duration
		: timed_run_duration;
	assign tr_start = run_start && timed_run_enable;
	assign tr_reached = (tr_state_q == TR_COUNT) && (timed_run_remaining_view_q == 16'h0000);

	always_comb
	begin
		tr_state_d = tr_state_q;
		remaining_d = timed_run_remaining_view_q;
		tr_flag_d = tr_flag_q;
		tr_stop_d = timed_run_stop_q;
		if (tr_start)
		begin
			// Each start reloads the full duration, so timing begins at zero
			tr_state_d = TR_COUNT;
			remaining_d = (tr_duration > TIMED_RUN_MAX) ? TIMED_RUN_MAX : tr_duration;
			tr_flag_d = 1'b0;
			tr_stop_d = 1'b0;
		end
		else
		begin
			case (tr_state_q)
				TR_IDLE:
				begin
					tr_stop_d = 1'b0;
				end
				TR_COUNT:
				begin
					if (!timed_run_enable || !running)
						tr_state_d = TR_IDLE;
					else if (tr_reached)
					begin
						// Stop request and flag rise together
						tr_state_d = TR_DONE;
						tr_stop_d = 1'b1;
						tr_flag_d = 1'b1;
					end
					else if (run_tick)
						remaining_d = timed_run_remaining_view_q - 16'h0001;
				end
				TR_DONE:
				begin
					// Stop is held until the drive has really stopped
					if (!running)
					begin
						tr_state_d = TR_IDLE;
						tr_stop_d = 1'b0;
					end
				end
				default:
				begin
					tr_state_d = TR_IDLE;
					tr_stop_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			delay_div_q <= 32'h0000_0000;
			run_div_q <= 32'h0000_0000;
		end
		else
		begin
			delay_div_q <= delay_tick ? 32'h0000_0000 : delay_div_q + 32'h0000_0001;
			// Tenth-minute base restarts with the run so the first step is a full one
			run_div_q <= (run_tick || tr_start) ? 32'h0000_0000 : run_div_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			run_freq_q <= 16'h0000;
			accel_set2_q <= 1'b0;
			decel_set2_q <= 1'b0;
			jog_meta_q <= 1'b0;
			jog_sync_q <= 1'b0;
			terminal_jog_run_q <= 1'b0;
		end
		else
		begin
			run_freq_q <= run_freq_d;
			accel_set2_q <= accel_set2_d;
			decel_set2_q <= decel_set2_d;
			jog_meta_q <= terminal_jog_pin;
			jog_sync_q <= jog_meta_q;
			terminal_jog_run_q <= terminal_jog_run_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			level1_q <= 1'b0;
			level2_q <= 1'b0;
			fwin1_q <= 1'b0;
			fwin2_q <= 1'b0;
			cwin1_q <= 1'b0;
			cwin2_q <= 1'b0;
			ai1_out_q <= 1'b0;
			heat_q <= 1'b0;
		end
		else
		begin
			level1_q <= level1_d;
			level2_q <= level2_d;
			fwin1_q <= fwin1_d;
			fwin2_q <= fwin2_d;
			cwin1_q <= in_window(meas.current, current_cfg.current_window1_centre,
				current_cfg.current_window1_width);
			cwin2_q <= in_window(meas.current, current_cfg.current_window2_centre,
				current_cfg.current_window2_width);
			ai1_out_q <= ai1_out_d;
			heat_q <= heat_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tr_state_q <= TR_IDLE;
			timed_run_remaining_view_q <= 16'h0000;
			tr_flag_q <= 1'b0;
			timed_run_stop_q <= 1'b0;
		end
		else
		begin
			tr_state_q <= tr_state_d;
			timed_run_remaining_view_q <= remaining_d;
			tr_flag_q <= tr_flag_d;
			timed_run_stop_q <= tr_stop_d;
		end
	end

	assign flags = '{level1_q, level2_q, fwin1_q, fwin2_q, zero_flag, over_flag,
		cwin1_q, cwin2_q, ai1_out_q, heat_q, tr_flag_q};

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_timed_start;
		tr_start ##1 (tr_state_q == TR_COUNT);
	endsequence
	sequence s_reach;
		tr_reached && timed_run_enable && running && !tr_start;
	endsequence

	chk_skip_jump: assert property (
		ramp_skip_band_enable && ramp_accel && in_band |=> run_freq_q == $past(skip_band_high))
		else $error("ramp dwelt inside skip band");
	chk_accel_select: assert property (
		accel_set2_q |-> $past(ramp_accel && meas.freq < accel_rate_switch_point))
		else $error("accel set 2 without cause");
	chk_decel_select: assert property (
		rate_switch_active && ramp_decel && meas.freq > decel_rate_switch_point |=> !decel_set2_q)
		else $error("decel set 2 above switch point");
	chk_rate_gate: assert property (
		!rate_switch_active |=> !accel_set2_q && !decel_set2_q)
		else $error("rate switch while gated off");
	chk_jog_entry: assert property (
		jog_priority_enable && running && terminal_jog_pin [*3] |=> terminal_jog_run_q)
		else $error("terminal jog not entered");
	chk_level_hold: assert property (
		level1_q && meas.freq >= freq_cfg.level1_freq_threshold |=> level1_q)
		else $error("level flag dropped inside hysteresis");
	chk_level2_set: assert property (
		meas.freq > freq_cfg.level2_freq_threshold |=> flags.freq_level_detector_two)
		else $error("second level flag missing");
	chk_fwin_centre: assert property (
		meas.freq == freq_cfg.freq_window2_centre |=> fwin2_q)
		else $error("window flag off at centre");
	chk_overcur_off: assert property (
		current_cfg.overcurrent_limit == 16'h0000 ##1 current_cfg.overcurrent_limit == 16'h0000
		|=> !over_flag)
		else $error("overcurrent flagged while disabled");
	chk_timed_restart: assert property (
		s_timed_start |-> timed_run_remaining_view_q <= TIMED_RUN_MAX && !tr_flag_q)
		else $error("timed run not restarted");
	chk_timed_stop: assert property (
		s_reach |=> timed_run_stop_q && tr_flag_q && tr_state_q == TR_DONE)
		else $error("stop and flag not together");
	chk_ai_range: assert property (
		meas.ai1_volt > analog_in1_high_limit |=> ai1_out_q)
		else $error("analogue over range not flagged");
	chk_heat_reach: assert property (
		meas.heatsink_temp == heatsink_temp_threshold |=> heat_q)
		else $error("heatsink threshold not flagged");
endmodule // drive_level_detection_monitor

/* File: drive_monitor_pkg.sv */
// Shared types, defaults and timing constants of the drive level detection monitor
package drive_monitor_pkg;

	// Clock and time bases
	localparam int CLK_PERIOD_NS = 10;
	localparam int DELAY_TICK_NS = 10_000_000;
	localparam int DELAY_TICK_CYCLES = DELAY_TICK_NS / CLK_PERIOD_NS;
	localparam int RUN_TICK_MS = 6000;
	localparam int RUN_TICK_CYCLES = RUN_TICK_MS * (1_000_000 / CLK_PERIOD_NS);

	// Percent settings are in 0.01 % steps, so full scale is this value
	localparam logic [31:0] PCT_FULL_SCALE = 32'h0000_2710;

	// Documented power-on values of the settings, in their port units
	localparam logic [15:0] DEF_FREQ_THRESHOLD = 16'h1388;
	localparam logic [15:0] DEF_FREQ_HYSTERESIS = 16'h01F4;
	localparam logic [15:0] DEF_FREQ_WINDOW_CENTRE = 16'h1388;
	localparam logic [15:0] DEF_WINDOW_WIDTH = 16'h0000;
	localparam logic [15:0] DEF_RATE_SWITCH_POINT = 16'h0000;
	localparam logic [15:0] DEF_ZERO_CURRENT_LEVEL = 16'h01F4;
	localparam logic [15:0] DEF_ZERO_CURRENT_DELAY = 16'h000A;
	localparam logic [15:0] DEF_OVERCURRENT_LIMIT = 16'h4E20;
	localparam logic [15:0] DEF_OVERCURRENT_DELAY = 16'h0000;
	localparam logic [15:0] DEF_CURRENT_WINDOW_CENTRE = 16'h2710;
	localparam logic [15:0] DEF_AI1_LOW_LIMIT = 16'h0136;
	localparam logic [15:0] DEF_AI1_HIGH_LIMIT = 16'h02A8;
	localparam logic [7:0] DEF_HEATSINK_THRESHOLD = 8'h5A;
	localparam logic [15:0] DEF_TIMED_RUN_DURATION = 16'h0000;
	localparam logic [15:0] TIMED_RUN_MAX = 16'hFDE8;

	// Timed run duration sources
	localparam logic [1:0] TR_SRC_SETTING = 2'h0;
	localparam logic [1:0] TR_SRC_ALT1 = 2'h1;
	localparam logic [1:0] TR_SRC_ALT2 = 2'h2;

	typedef enum {TR_IDLE, TR_COUNT, TR_DONE} timed_run_state_t;

	// Frequency 0.01 Hz, current 0.01 % of rated, voltage 0.01 V, temperature deg C
	typedef struct packed {
		logic [15:0] freq;
		logic [15:0] current;
		logic [15:0] ai1_volt;
		logic [7:0] heatsink_temp;
	} measure_t;

	typedef struct packed {
		logic [15:0] level1_freq_threshold;
		logic [15:0] level1_freq_hysteresis;
		logic [15:0] level2_freq_threshold;
		logic [15:0] level2_freq_hysteresis;
		logic [15:0] freq_window1_centre;
		logic [15:0] freq_window1_width;
		logic [15:0] freq_window2_centre;
		logic [15:0] freq_window2_width;
	} freq_cfg_t;

	typedef struct packed {
		logic [15:0] zero_current_level;
		logic [15:0] zero_current_delay;
		logic [15:0] overcurrent_limit;
		logic [15:0] overcurrent_delay;
		logic [15:0] current_window1_centre;
		logic [15:0] current_window1_width;
		logic [15:0] current_window2_centre;
		logic [15:0] current_window2_width;
	} current_cfg_t;

	typedef struct packed {
		logic freq_level_detector_one;
		logic freq_level_detector_two;
		logic freq_window1;
		logic freq_window2;
		logic zero_current;
		logic overcurrent;
		logic current_window1;
		logic current_window2;
		logic ai1_out_of_range;
		logic heatsink_temp_reached;
		logic timed_run_reached;
	} det_flags_t;

endpackage

/* File: delay_qualifier.sv */
// Condition detector that asserts its flag once the condition has held longer than a delay
`timescale 1ns/1ns
module delay_qualifier (
	input wire logic clk,
	input wire logic rst,
	input wire logic cond,
	input wire logic tick,
	input wire logic [15:0] delay,
	output logic flag_q
);
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic flag_d;
	logic count_full;

	assign count_full = (count_q == 16'hFFFF);
	// Counter clears as soon as the condition drops, so short glitches never add up
	assign count_d = !cond ? 16'h0000 : (tick && !count_full) ? count_q + 16'h0001 : count_q;
	assign flag_d = cond && (count_q > delay);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count_q <= 16'h0000;
			flag_q <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			flag_q <= flag_d;
		end
	end

	chk_drop_clears: assert property (@(posedge clk) disable iff (rst)
		!cond |=> !flag_q && count_q == 16'h0000)
		else $error("flag or counter survived a dropped condition");
	chk_qualified_set: assert property (@(posedge clk) disable iff (rst)
		cond && $rose(flag_q) |-> $past(count_q) > $past(delay) && $past(cond))
		else $error("flag set before delay elapsed");
endmodule // delay_qualifier

/* File: drive_plant_model.sv */
// Plant model: power stage measurements and the jog terminal contact
`timescale 1ns/1ns
module drive_plant_model (
	input wire logic clk,
	input wire logic rst,
	input wire drive_monitor_pkg::measure_t meas_set,
	input wire logic jog_cmd,
	output drive_monitor_pkg::measure_t meas,
	output wire logic terminal_jog_pin
);
	import drive_monitor_pkg::*;
	// Sensors sample once a clock, so readings lag the set point by one cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			meas <= '0;
		else
			meas <= meas_set;
	end
	// The contact moves off the clock grid to exercise the synchroniser
	assign #3 terminal_jog_pin = jog_cmd;
endmodule // drive_plant_model

/* File: drive_level_detection_monitor_tb.sv */
// Self-checking bench of the drive level detection monitor
`timescale 1ns/1ns
module drive_level_detection_monitor_tb;
	import drive_monitor_pkg::*;
	typedef struct packed {
		logic [15:0] f;
		logic [15:0] c;
		logic [15:0] v;
		logic [7:0] t;
		logic [10:0] e;
	} row_t;
	// Rows run in order: level flags depend on the previous row through hysteresis
	localparam row_t ROWS [7] = '{
		'{16'h0BB8, 16'h1388, 16'h01F4, 8'h59, 11'h288},
		'{16'h1388, 16'h2710, 16'h02A9, 8'h5A, 11'h316},
		'{16'h1389, 16'h1194, 16'h0135, 8'h00, 11'h60C},
		'{16'h128F, 16'h157C, 16'h02A8, 8'hFF, 11'h60A},
		'{16'h128D, 16'h157D, 16'h0136, 8'h0A, 11'h200},
		'{16'h076D, 16'h1193, 16'h0000, 8'h0A, 11'h204},
		'{16'h076B, 16'h0258, 16'h0190, 8'h0A, 11'h000}};
	logic clk = 1'b0;
	logic rst = 1'b1;
	measure_t ms = '{16'h0000, 16'h1388, 16'h01F4, 8'h14};
	measure_t meas;
	freq_cfg_t fc = '{16'h1388, 16'h01F4, 16'h07D0, 16'h01F4, 16'h1388, 16'h0000,
		16'h0BB8, 16'h03E8};
	current_cfg_t cc = '{16'h01F4, 16'h0002, 16'h4E20, 16'h0000, 16'h2710, 16'h0000,
		16'h1388, 16'h01F4};
	logic [15:0] ramp_freq = 16'h09C4;
	logic [15:0] skip_lo = 16'h07D0;
	logic [15:0] skip_hi = 16'h0BB8;
	logic [15:0] asp = 16'h0BB8;
	logic [15:0] dsp = 16'h0FA0;
	logic [15:0] fmax = 16'h2710;
	logic [15:0] ai_lo = 16'h0136;
	logic [15:0] ai_hi = 16'h02A8;
	logic [7:0] heat_thr = 8'h5A;
	logic [15:0] trd = 16'h0002;
	logic [15:0] tra1 = 16'h0003;
	logic [15:0] tra2 = 16'h0001;
	logic ramp_accel = 1'b0;
	logic ramp_decel = 1'b0;
	logic skip_en = 1'b0;
	logic m1 = 1'b1;
	logic dsel = 1'b0;
	logic jog_en = 1'b0;
	logic jog_cmd = 1'b0;
	logic running = 1'b1;
	logic run_start = 1'b0;
	logic tr_en = 1'b1;
	logic [1:0] tr_sel = 2'h0;
	wire logic jog_pin;
	logic [15:0] run_freq_q;
	logic [15:0] rem;
	logic acc2;
	logic dec2;
	logic jog_run;
	logic stop;
	det_flags_t flags;
	int n_mismatch = 0;
	int check_count = 0;
	int t;
	int d;

	always #5 clk = ~clk;

	drive_plant_model i_plant (.clk(clk), .rst(rst), .meas_set(ms), .jog_cmd(jog_cmd),
		.meas(meas), .terminal_jog_pin(jog_pin));

	drive_level_detection_monitor #(.DELAY_TICK_LEN(4), .RUN_TICK_LEN(8)) i_dut (
		.clk(clk), .rst(rst), .meas(meas), .max_freq(fmax), .freq_cfg(fc),
		.current_cfg(cc), .ramp_freq(ramp_freq), .ramp_accel(ramp_accel),
		.ramp_decel(ramp_decel), .ramp_skip_band_enable(skip_en), .skip_band_low(skip_lo),
		.skip_band_high(skip_hi), .accel_rate_switch_point(asp),
		.decel_rate_switch_point(dsp), .motor_one_selected(m1),
		.multi_function_input_ramp_select(dsel), .jog_priority_enable(jog_en),
		.terminal_jog_pin(jog_pin), .running(running), .run_start(run_start),
		.timed_run_enable(tr_en), .timed_run_source_select(tr_sel),
		.timed_run_duration(trd), .timed_run_alt1_duration(tra1),
		.timed_run_alt2_duration(tra2), .analog_in1_low_limit(ai_lo),
		.analog_in1_high_limit(ai_hi), .heatsink_temp_threshold(heat_thr),
		.run_freq_q(run_freq_q), .accel_set2_q(acc2), .decel_set2_q(dec2),
		.terminal_jog_run_q(jog_run), .timed_run_stop_q(stop),
		.timed_run_remaining_view_q(rem), .flags(flags));

	task automatic conclude();
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// A wait that ran out ends the run, since later steps assume its outcome
	task automatic bound(input string nm, input int lim);
		if (t >= lim)
		begin
			chk(nm, 16'h0001, 16'h0000);
			conclude();
		end
	endtask

	task automatic pulse();
		run_start = 1'b1;
		cyc(1);
		run_start = 1'b0;
	endtask

	task automatic rate(input logic [15:0] f, input logic a, input logic m, input logic s);
		ms.freq = f;
		ramp_accel = a;
		ramp_decel = !a;
		m1 = m;
		dsel = s;
		cyc(3);
	endtask

	initial
	begin
		cyc(10);
		chk("reset_flags", 16'h0000, {5'h00, flags});
		chk("reset_stop", 16'h0000, {15'h0000, stop});
		rst = 1'b0;
		foreach (ROWS[i])
		begin
			ms = '{ROWS[i].f, ROWS[i].c, ROWS[i].v, ROWS[i].t};
			cyc(3);
			chk("flags", {5'h00, ROWS[i].e}, {5'h00, flags});
		end
		// Limits and the width base move too, so a port wired to a fixed value shows up
		fmax = 16'h1388;
		heat_thr = 8'h0A;
		ai_lo = 16'h0191;
		ms.freq = 16'h0FA0;
		cyc(3);
		chk("flags_limits", 16'h0206, {5'h00, flags});
		fmax = 16'h2710;
		heat_thr = 8'h5A;
		ai_lo = 16'h0136;
		ms.current = 16'h01F4;
		cyc(5);
		chk("zero_early", 16'h0000, {15'h0000, flags.zero_current});
		for (t = 0; t < 30 && flags.zero_current !== 1'b1; t++)
			cyc(1);
		bound("zero_wait", 30);
		ms.current = 16'h01F5;
		cyc(3);
		chk("zero_clear", 16'h0000, {15'h0000, flags.zero_current});
		ms.current = 16'h01F4;
		cyc(5);
		chk("zero_restart", 16'h0000, {15'h0000, flags.zero_current});
		cc.overcurrent_limit = 16'h0000;
		ms.current = 16'h7530;
		cyc(20);
		chk("oc_off", 16'h0000, {15'h0000, flags.overcurrent});
		cc.overcurrent_limit = 16'h4E20;
		for (t = 0; t < 10 && flags.overcurrent !== 1'b1; t++)
			cyc(1);
		bound("oc_wait", 10);
		ms.current = 16'h4E20;
		cyc(3);
		chk("oc_clear", 16'h0000, {15'h0000, flags.overcurrent});
		rate(16'h0BB7, 1'b1, 1'b1, 1'b0);
		chk("acc_below", 16'h0001, {15'h0000, acc2});
		rate(16'h0BB8, 1'b1, 1'b1, 1'b0);
		chk("acc_equal", 16'h0000, {15'h0000, acc2});
		// Between the two switch points, so a swapped switch point is caught
		rate(16'h0BB9, 1'b0, 1'b1, 1'b0);
		chk("dec_below", 16'h0001, {15'h0000, dec2});
		rate(16'h0FA1, 1'b0, 1'b1, 1'b0);
		chk("dec_above", 16'h0000, {15'h0000, dec2});
		rate(16'h0BB7, 1'b1, 1'b0, 1'b0);
		chk("acc_motor2", 16'h0000, {15'h0000, acc2});
		rate(16'h0BB7, 1'b1, 1'b1, 1'b1);
		chk("acc_terminal", 16'h0000, {15'h0000, acc2});
		skip_en = 1'b1;
		rate(16'h0BB7, 1'b1, 1'b1, 1'b0);
		chk("skip_accel", 16'h0BB8, run_freq_q);
		rate(16'h0BB7, 1'b0, 1'b1, 1'b0);
		chk("skip_decel", 16'h07D0, run_freq_q);
		skip_en = 1'b0;
		cyc(2);
		chk("skip_off", 16'h09C4, run_freq_q);
		skip_en = 1'b1;
		ramp_freq = 16'h07D0;
		cyc(2);
		chk("skip_edge", 16'h07D0, run_freq_q);
		jog_en = 1'b1;
		jog_cmd = 1'b1;
		cyc(3);
		chk("jog_on", 16'h0001, {15'h0000, jog_run});
		jog_en = 1'b0;
		cyc(3);
		chk("jog_off", 16'h0000, {15'h0000, jog_run});
		for (int s = 0; s < 4; s++)
		begin
			tr_sel = 2'(s);
			d = (s == 1) ? 3 : (s == 2) ? 1 : 2;
			pulse();
			cyc(5);
			pulse();
			chk("remaining", 16'(d), rem);
			for (t = 0; t < 60 && stop !== 1'b1; t++)
				cyc(1);
			bound("stop_wait", 60);
			chk("run_len", 16'h0001, {15'h0000, t >= 8 * d - 1 && t <= 8 * d + 3});
			chk("run_flag", 16'h0001, {15'h0000, flags.timed_run_reached});
			chk("rem_end", 16'h0000, rem);
			cyc(3);
			chk("stop_held", 16'h0001, {15'h0000, stop});
			running = 1'b0;
			cyc(2);
			chk("stop_clear", 16'h0000, {15'h0000, stop});
			running = 1'b1;
		end
		tr_en = 1'b0;
		pulse();
		cyc(30);
		chk("timed_off", 16'h0000, {15'h0000, stop});
		conclude();
	end
endmodule // drive_level_detection_monitor_tb
